// ===== rtl/bvm_ctrl.sv
// Purpose: Brown-out detector and early-warning monitor control with Avalon-MM registers
// Assumes: Comparator and ready pins are asynchronous; sleep, debug and unlock come from clock domain
// Notes: One wait state on every bus access
// Summary of operation
// - Threshold, active mode and sleep mode load from fuses at every reset.
// - Threshold level and active mode are read-only to software.
// - Software may overwrite the deep-sleep mode field in the first control register.
// - Deep sleep switches to the sleep mode; waking returns to the active mode.
// - After wake-up the detector runs in the active mode setting.
// - Detector runs continuously or is powered briefly once per sample period.
// - Supply below brown-out threshold requests a system reset.
// - Setting the warning interrupt enable switches the warning monitor on.
// - Warning interrupt on falling, rising or either crossing per trigger field.
// - Warning monitor off while detector off; sampled when detector is sampled.
// - Enabling with both-direction trigger sets the flag whenever the detector is not in its off state.
// - Warning threshold chosen by level field, percent above brown-out level.
// - Warning interrupt is delivered on vector five.
// - Warning interrupt not taken while the CPU is halted in debug.
// - A warning condition sets the warning flag.
// - Request stands while enable and flag are set, until flag cleared.
// - Protected write without unlock leaves the field unchanged.
// - Sleep mode field is protected with the I/O register key.
// - Active mode codes: off, continuous, sampled, continuous with wake hold.
// - Trigger codes: falling, rising, both; other codes reserved.
// - Warning level codes: off, five, fifteen, twenty-five percent above.
// - Sample rate bit selects 128 Hz at zero, 32 Hz at one.
`timescale 1ns/1ps
`default_nettype none
`include "bvm_defs.svh"
module bvm_ctrl import bvm_pkg::*; #(
  parameter logic [23:0] DIV_FAST = 24'(`BVM_DIV_FAST),
  parameter logic [23:0] DIV_SLOW = 24'(`BVM_DIV_SLOW)
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire bvm_fuse_t brownout_config_fuse,
  input wire logic deep_sleep,
  input wire logic cpu_debug_halt,
  input wire logic io_register_unlock_key,
  input wire logic cpu_instr_step,
  input wire logic cmp_below_brownout,
  input wire logic cmp_below_warning,
  input wire logic detector_ready,
  output bvm_analog_t analog_ctrl,
  output logic system_reset_req,
  output logic cpu_wake_hold,
  output logic warning_irq,
  output logic [7:0] warning_irq_vector
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    DS_OFF = 4'b0001,
    DS_CONT = 4'b0010,
    DS_WAIT = 4'b0100,
    DS_ON = 4'b1000
  } bvm_det_state_t;

  bvm_det_state_t state_reg;
  bvm_det_state_t state_next;
  logic sample_rate_reg;
  logic [1:0] active_mode_reg;
  logic [1:0] sleep_mode_reg;
  logic [2:0] brownout_level_reg;
  logic [1:0] warning_threshold_level_reg;
  logic warning_irq_enable_reg;
  logic [1:0] warning_trigger_cfg_reg;
  logic warning_irq_flag_reg;
  logic warning_below_status_reg;
  logic [2:0] unlock_count_reg;
  logic ack_reg;
  logic [7:0] on_count_reg;
  logic deep_sleep_reg;
  logic irq_enable_prev_reg;
  logic below_bod_sync;
  logic below_warn_sync;
  logic ready_sync;
  logic sample_tick;
  logic [1:0] eff_mode;
  logic mode_cont;
  logic mode_sampled;
  logic meas_now;
  logic warn_active;
  logic wr_fire;
  logic [3:0] reg_index;
  logic addr_ok;
  logic [7:0] read_value;
  logic warn_fall;
  logic warn_rise;
  logic warn_event;
  logic flag_clear;

  // ----------------------------------------------------------------
  // Input synchronisers and sample divider
  // ----------------------------------------------------------------
  bvm_sync #(.WIDTH(3)) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .async_in({cmp_below_brownout, cmp_below_warning, detector_ready}),
    .sync_out({below_bod_sync, below_warn_sync, ready_sync})
  );

  bvm_rate_tick #(.DIV_FAST(DIV_FAST), .DIV_SLOW(DIV_SLOW)) u_tick (
    .clock(clock),
    .reset_n(reset_n),
    .enable(state_reg == DS_WAIT),
    .slow_sel(sample_rate_reg),
    .tick(sample_tick)
  );

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  // Byte address is the index times four; misaligned addresses are unmapped
  assign reg_index = address[5:2];
  assign addr_ok = (address[1:0] == 2'h0);
  assign waitrequest = (read | write) & ~ack_reg;
  assign wr_fire = write & ack_reg & addr_ok & byteenable[0];

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (read | write) & ~ack_reg;
    end
  end

  always_comb begin
    read_value = 8'h00;
    if (addr_ok) begin
      case (reg_index)
        `BVM_IDX_MODE_CTRL: read_value = {3'h0, sample_rate_reg, active_mode_reg, sleep_mode_reg};
        `BVM_IDX_LEVEL_SEL: read_value = {5'h0, brownout_level_reg};
        `BVM_IDX_WARN_LEVEL: read_value = {6'h0, warning_threshold_level_reg};
        `BVM_IDX_WARN_IRQ_CTRL: read_value = {5'h0, warning_trigger_cfg_reg, warning_irq_enable_reg};
        `BVM_IDX_WARN_FLAGS: read_value = {7'h0, warning_irq_flag_reg};
        `BVM_IDX_WARN_STATUS: read_value = {7'h0, warning_below_status_reg};
        default: read_value = 8'h00;
      endcase
    end
  end

  // Read data is captured in the wait cycle so it is stable at the accepting edge
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      readdata <= 32'h0;
    end else if (read & ~ack_reg) begin
      readdata <= {24'h0, read_value};
    end
  end

  // ----------------------------------------------------------------
  // Fuse-loaded configuration and protected sleep mode
  // ----------------------------------------------------------------
  // Fuse copy is taken by the synchronous reset branch on every reset
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sample_rate_reg <= brownout_config_fuse.sample_rate_select;
      active_mode_reg <= brownout_config_fuse.active_mode;
      brownout_level_reg <= brownout_config_fuse.brownout_threshold_level;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sleep_mode_reg <= brownout_config_fuse.sleep_mode;
    end else if (wr_fire && reg_index == `BVM_IDX_MODE_CTRL && unlock_count_reg != 3'h0) begin
      // Only the sleep field is writable; the other fields ignore the write
      sleep_mode_reg <= writedata[`BVM_SLEEP_LSB +: 2];
    end
  end

  // Window opened by the I/O register key, counted down per retired instruction
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      unlock_count_reg <= 3'h0;
    end else if (io_register_unlock_key) begin
      unlock_count_reg <= `BVM_UNLOCK_WINDOW;
    end else if (wr_fire && reg_index == `BVM_IDX_MODE_CTRL) begin
      unlock_count_reg <= 3'h0;
    end else if (cpu_instr_step && unlock_count_reg != 3'h0) begin
      unlock_count_reg <= unlock_count_reg - 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Warning monitor control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      warning_threshold_level_reg <= `BVM_WARN_LEVEL_RESET;
    end else if (wr_fire && reg_index == `BVM_IDX_WARN_LEVEL) begin
      warning_threshold_level_reg <= writedata[1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      {warning_trigger_cfg_reg, warning_irq_enable_reg} <= `BVM_IRQ_CTRL_RESET;
    end else if (wr_fire && reg_index == `BVM_IDX_WARN_IRQ_CTRL) begin
      warning_irq_enable_reg <= writedata[`BVM_IRQ_EN_BIT];
      warning_trigger_cfg_reg <= writedata[`BVM_TRIG_CFG_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------
  // Detector mode selection and sequencing
  // ----------------------------------------------------------------
  // Reserved sleep code and threshold code zero both act as disabled
  assign eff_mode = deep_sleep ? sleep_mode_reg : active_mode_reg;
  assign mode_cont = (brownout_level_reg != 3'h0) &&
                     (eff_mode == BVM_MODE_CONT || (!deep_sleep && eff_mode == BVM_MODE_CONT_WAIT));
  assign mode_sampled = (brownout_level_reg != 3'h0) && eff_mode == BVM_MODE_SAMPLED;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DS_OFF: begin
        if (mode_cont) begin
          state_next = DS_CONT;
        end else if (mode_sampled) begin
          state_next = DS_WAIT;
        end
      end
      DS_CONT: begin
        if (!mode_cont) begin
          state_next = mode_sampled ? DS_WAIT : DS_OFF;
        end
      end
      DS_WAIT: begin
        if (mode_cont) begin
          state_next = DS_CONT;
        end else if (!mode_sampled) begin
          state_next = DS_OFF;
        end else if (sample_tick) begin
          state_next = DS_ON;
        end
      end
      DS_ON: begin
        if (mode_cont) begin
          state_next = DS_CONT;
        end else if (!mode_sampled) begin
          state_next = DS_OFF;
        end else if (on_count_reg == 8'(`BVM_SAMPLE_ON_CYCLES - 1)) begin
          state_next = DS_WAIT;
        end
      end
      default: state_next = DS_OFF;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg <= DS_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n || state_reg != DS_ON) begin
      on_count_reg <= 8'h0;
    end else begin
      on_count_reg <= on_count_reg + 8'h1;
    end
  end

  // Continuous mode measures every cycle; sampled mode at the end of the on window
  assign meas_now = (state_reg == DS_CONT) ||
                    (state_reg == DS_ON && on_count_reg == 8'(`BVM_SAMPLE_ON_CYCLES - 1));

  // ----------------------------------------------------------------
  // Brown-out reset request and wake hold
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n || state_reg == DS_OFF) begin
      system_reset_req <= 1'b0;
    end else if (meas_now) begin
      system_reset_req <= below_bod_sync;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      deep_sleep_reg <= 1'b0;
    end else begin
      deep_sleep_reg <= deep_sleep;
    end
  end

  // Execution is held after wake until the analog detector reports it is running
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cpu_wake_hold <= 1'b0;
    end else if (deep_sleep_reg && !deep_sleep && active_mode_reg == BVM_MODE_CONT_WAIT &&
                 brownout_level_reg != 3'h0) begin
      cpu_wake_hold <= 1'b1;
    end else if (state_reg == DS_CONT && ready_sync) begin
      cpu_wake_hold <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Warning monitor status, flag and request
  // ----------------------------------------------------------------
  assign warn_active = (state_reg != DS_OFF) && warning_irq_enable_reg &&
                       (warning_threshold_level_reg != 2'h0);

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      warning_below_status_reg <= 1'b0;
    end else if (warn_active && meas_now) begin
      warning_below_status_reg <= below_warn_sync;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      irq_enable_prev_reg <= 1'b0;
    end else begin
      irq_enable_prev_reg <= warning_irq_enable_reg;
    end
  end

  assign warn_fall = warn_active && meas_now && !warning_below_status_reg && below_warn_sync;
  assign warn_rise = warn_active && meas_now && warning_below_status_reg && !below_warn_sync;

  always_comb begin
    case (warning_trigger_cfg_reg)
      BVM_TRIG_FALLING: warn_event = warn_fall;
      BVM_TRIG_RISING: warn_event = warn_rise;
      BVM_TRIG_BOTH: warn_event = warn_fall | warn_rise;
      default: warn_event = 1'b0;
    endcase
    // Turning the enable on with both directions raises the flag unless the detector is in its off state
    if (warning_irq_enable_reg && !irq_enable_prev_reg && state_reg != DS_OFF &&
        warning_trigger_cfg_reg == BVM_TRIG_BOTH) begin
      warn_event = 1'b1;
    end
  end

  assign flag_clear = wr_fire && reg_index == `BVM_IDX_WARN_FLAGS && writedata[`BVM_FLAG_BIT];

  // A new event in the clearing cycle wins so no crossing is lost
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      warning_irq_flag_reg <= 1'b0;
    end else if (warn_event) begin
      warning_irq_flag_reg <= 1'b1;
    end else if (flag_clear) begin
      warning_irq_flag_reg <= 1'b0;
    end
  end

  assign warning_irq = warning_irq_enable_reg & warning_irq_flag_reg & ~cpu_debug_halt;
  assign warning_irq_vector = `BVM_WARN_IRQ_VECTOR;

  assign analog_ctrl.detector_power = (state_reg == DS_CONT) || (state_reg == DS_ON);
  assign analog_ctrl.brownout_threshold_level = brownout_level_reg;
  assign analog_ctrl.warning_threshold_level = warning_threshold_level_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_locked_write_ignored;
    @(posedge clock) disable iff (!reset_n)
      (wr_fire && reg_index == `BVM_IDX_MODE_CTRL && unlock_count_reg == 3'h0)
      |=> $stable(sleep_mode_reg);
  endproperty
  a_locked_write_ignored: assert property (p_locked_write_ignored) else $error("locked sleep write took effect");

  property p_ro_fields;
    @(posedge clock) disable iff (!reset_n)
      $past(reset_n) |-> $stable(active_mode_reg) && $stable(brownout_level_reg);
  endproperty
  a_ro_fields: assert property (p_ro_fields) else $error("fuse field changed outside reset");

  property p_unlocked_write;
    @(posedge clock) disable iff (!reset_n)
      (wr_fire && reg_index == `BVM_IDX_MODE_CTRL && unlock_count_reg != 3'h0 && !io_register_unlock_key)
      |=> sleep_mode_reg == $past(writedata[1:0]);
  endproperty
  a_unlocked_write: assert property (p_unlocked_write) else $error("unlocked sleep write lost");

  property p_window_length;
    @(posedge clock) disable iff (!reset_n)
      io_register_unlock_key ##1 (cpu_instr_step && !io_register_unlock_key && !wr_fire)[*4]
      |=> unlock_count_reg == 3'h0;
  endproperty
  a_window_length: assert property (p_window_length) else $error("unlock window outlasts four steps");

  property p_sample_on_width;
    @(posedge clock) disable iff (!reset_n)
      (state_reg == DS_WAIT && state_next == DS_ON) |=> (state_reg == DS_ON)[*8];
  endproperty
  a_sample_on_width: assert property (p_sample_on_width) else $error("sample window too short");

  property p_reset_req;
    @(posedge clock) disable iff (!reset_n)
      (state_reg == DS_CONT && mode_cont && below_bod_sync) |=> system_reset_req;
  endproperty
  a_reset_req: assert property (p_reset_req) else $error("brown-out reset not requested");

  property p_monitor_off;
    @(posedge clock) disable iff (!reset_n)
      (state_reg == DS_OFF) |=> $stable(warning_below_status_reg);
  endproperty
  a_monitor_off: assert property (p_monitor_off) else $error("monitor active with detector off");

  property p_flag_set;
    @(posedge clock) disable iff (!reset_n)
      warn_event |=> warning_irq_flag_reg;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("warning flag not set on event");

  property p_flag_clear;
    @(posedge clock) disable iff (!reset_n)
      (flag_clear && !warn_event) |=> !warning_irq_flag_reg ##1 (warning_irq_flag_reg == $past(warn_event));
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("warning flag not cleared");

  property p_irq_level;
    @(posedge clock) disable iff (!reset_n)
      (warning_irq_flag_reg && !flag_clear) |=> warning_irq_flag_reg;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("warning request dropped before clear");

  property p_debug_block;
    @(posedge clock) disable iff (!reset_n)
      cpu_debug_halt |-> !warning_irq;
  endproperty
  a_debug_block: assert property (p_debug_block) else $error("request during debug halt");

  property p_both_enable;
    @(posedge clock) disable iff (!reset_n)
      ($rose(warning_irq_enable_reg) && state_reg != DS_OFF && warning_trigger_cfg_reg == BVM_TRIG_BOTH)
      |=> warning_irq_flag_reg;
  endproperty
  a_both_enable: assert property (p_both_enable) else $error("enable with both trigger did not set flag");

  property p_sleep_mode_used;
    @(posedge clock) disable iff (!reset_n)
      (deep_sleep && sleep_mode_reg == BVM_MODE_OFF) |=> ##1 state_reg == DS_OFF || !$past(deep_sleep);
  endproperty
  a_sleep_mode_used: assert property (p_sleep_mode_used) else $error("sleep mode not applied");

endmodule // bvm_ctrl
`default_nettype wire

// ===== shared/bvm_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the brown-out monitor
// Assumes: 200 MHz system clock
// Notes: Register byte address is four times the register index
`ifndef BVM_DEFS_SVH
`define BVM_DEFS_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define BVM_IDX_MODE_CTRL 4'h0
`define BVM_IDX_LEVEL_SEL 4'h1
`define BVM_IDX_WARN_LEVEL 4'h8
`define BVM_IDX_WARN_IRQ_CTRL 4'h9
`define BVM_IDX_WARN_FLAGS 4'ha
`define BVM_IDX_WARN_STATUS 4'hb

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define BVM_SLEEP_LSB 0
`define BVM_ACTIVE_LSB 2
`define BVM_SAMPLE_RATE_BIT 4
`define BVM_IRQ_EN_BIT 0
`define BVM_TRIG_CFG_LSB 1
`define BVM_FLAG_BIT 0
`define BVM_WARN_LEVEL_RESET 2'h0
`define BVM_IRQ_CTRL_RESET 3'h0
`define BVM_WARN_IRQ_VECTOR 8'h05

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BVM_CLOCK_HZ 200000000
`define BVM_RATE_FAST_HZ 128
`define BVM_RATE_SLOW_HZ 32
`define BVM_DIV_FAST (`BVM_CLOCK_HZ / `BVM_RATE_FAST_HZ)
`define BVM_DIV_SLOW (`BVM_CLOCK_HZ / `BVM_RATE_SLOW_HZ)
`define BVM_SAMPLE_ON_NS 1000
`define BVM_SAMPLE_ON_CYCLES ((`BVM_SAMPLE_ON_NS * (`BVM_CLOCK_HZ / 1000000) + 999) / 1000)
`define BVM_UNLOCK_WINDOW 3'h4

`endif

// ===== shared/bvm_pkg.sv
// Purpose: Types shared by the brown-out monitor files
// Assumes: Nothing
// Notes: Numeric constants live in bvm_defs.svh
package bvm_pkg;

  typedef enum logic [1:0] {
    BVM_MODE_OFF = 2'h0,
    BVM_MODE_CONT = 2'h1,
    BVM_MODE_SAMPLED = 2'h2,
    BVM_MODE_CONT_WAIT = 2'h3
  } bvm_mode_t;

  typedef enum logic [1:0] {
    BVM_TRIG_FALLING = 2'h0,
    BVM_TRIG_RISING = 2'h1,
    BVM_TRIG_BOTH = 2'h2
  } bvm_trig_t;

  typedef struct packed {
    logic sample_rate_select;
    logic [1:0] active_mode;
    logic [1:0] sleep_mode;
    logic [2:0] brownout_threshold_level;
  } bvm_fuse_t;

  typedef struct packed {
    logic detector_power;
    logic [2:0] brownout_threshold_level;
    logic [1:0] warning_threshold_level;
  } bvm_analog_t;

endpackage : bvm_pkg

// ===== rtl/bvm_sync.sv
// Purpose: Two flip-flop synchroniser for a group of levels
// Assumes: Inputs are asynchronous levels
// Notes: Stage one is read by stage two only
`timescale 1ns/1ps
`default_nettype none
module bvm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      stage1_reg <= '0;
      sync_out <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end
endmodule // bvm_sync
`default_nettype wire

// ===== rtl/bvm_rate_tick.sv
// Purpose: Divider giving one-cycle sample ticks at one of two rates
// Assumes: Divisors are at least two
// Notes: Restarts the period whenever it is not enabled
`timescale 1ns/1ps
`default_nettype none
module bvm_rate_tick #(
  parameter logic [23:0] DIV_FAST = 24'd1562500,
  parameter logic [23:0] DIV_SLOW = 24'd6250000
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic slow_sel,
  output logic tick
);
  logic [23:0] count_reg;
  logic [23:0] limit;

  assign limit = slow_sel ? DIV_SLOW - 24'h1 : DIV_FAST - 24'h1;

  always_ff @(posedge clock) begin
    if (!reset_n || !enable) begin
      count_reg <= 24'h0;
      tick <= 1'b0;
    end else if (count_reg >= limit) begin
      count_reg <= 24'h0;
      tick <= 1'b1;
    end else begin
      count_reg <= count_reg + 24'h1;
      tick <= 1'b0;
    end
  end
endmodule // bvm_rate_tick
`default_nettype wire

// ===== test/bvm_supply_model.sv
// Purpose: Supply comparator model facing the brown-out monitor
// Assumes: Bench commands the supply level
// Notes: Unpowered comparators report a healthy supply
`timescale 1ns/1ps
`default_nettype none
module bvm_supply_model import bvm_pkg::*; (
  input wire logic clock,
  input wire bvm_analog_t analog_ctrl,
  input wire logic low_bod,
  input wire logic low_warn,
  output logic cmp_below_brownout,
  output logic cmp_below_warning,
  output logic detector_ready
);
  logic [1:0] pwr_reg;
  // Ready lags power by two cycles, as a real bias settles
  always_ff @(posedge clock) begin
    pwr_reg <= {pwr_reg[0], analog_ctrl.detector_power};
  end
  assign cmp_below_brownout = analog_ctrl.detector_power & low_bod;
  assign cmp_below_warning = analog_ctrl.detector_power & low_warn;
  assign detector_ready = pwr_reg[1];
endmodule // bvm_supply_model
`default_nettype wire

// ===== test/tb.sv
// Purpose: Register and event tests of the brown-out monitor
// Assumes: Fuse gives continuous active, sampled sleep, level 3
// Notes: Read data is taken at the accepting edge, where waitrequest is low
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bvm_pkg::*;
  logic clock = 0, reset_n = 0, read = 0, write = 0, deep_sleep = 0, dbg = 0, key = 0, lb = 0, lw = 0, step = 0;
  bvm_fuse_t fuse = 8'h33;
  logic [5:0] address = 6'h0;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic waitrequest, cbb, cbw, rdy, sreq, irq, hold;
  logic [7:0] vec;
  bvm_analog_t ana;
  int num_errors = 0, cmp_count = 0;
  always #2.5 clock = ~clock;
  bvm_ctrl #(.DIV_FAST(24'd20), .DIV_SLOW(24'd40)) dut (.clock(clock), .reset_n(reset_n), .address(address),
    .read(read), .write(write), .byteenable(4'h1), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .brownout_config_fuse(fuse), .deep_sleep(deep_sleep), .cpu_debug_halt(dbg),
    .io_register_unlock_key(key), .cpu_instr_step(step), .cmp_below_brownout(cbb), .cmp_below_warning(cbw),
    .detector_ready(rdy), .analog_ctrl(ana), .system_reset_req(sreq), .cpu_wake_hold(hold),
    .warning_irq(irq), .warning_irq_vector(vec));
  bvm_supply_model sup (.clock(clock), .analog_ctrl(ana), .low_bod(lb), .low_warn(lw),
    .cmp_below_brownout(cbb), .cmp_below_warning(cbw), .detector_ready(rdy));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Waits as long as the slave asks; only the watchdog ends a hung access
  task bus(input logic rd_en, input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    read <= rd_en;
    write <= !rd_en;
    address <= a;
    writedata <= {24'h0, d};
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task rd(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b1, a, 8'h0);
    chk(q, exp);
  endtask
  task wait_chk(input int n, input logic got_sel, input logic exp);
    repeat (n) @(posedge clock);
    chk(got_sel ? irq : sreq, exp);
  endtask
  // Key pulse, then the given number of retired instructions
  task unlock(input int steps);
    @(posedge clock) key <= 1'b1;
    @(posedge clock) key <= 1'b0;
    if (steps > 0) begin
      step <= 1'b1;
      repeat (steps) @(posedge clock);
      step <= 1'b0;
    end
  endtask
  task give_verdict;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100us;
    num_errors++;
    give_verdict;
  end
  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    rd(6'h00, 32'h06);
    rd(6'h04, 32'h03);
    bus(1'b0, 6'h04, 8'h00);
    rd(6'h04, 32'h03);
    bus(1'b0, 6'h00, 8'hff);
    rd(6'h00, 32'h06);
    unlock(0);
    bus(1'b0, 6'h00, 8'hfc);
    rd(6'h00, 32'h04);
    rd(6'h08, 32'h0);
    deep_sleep <= 1'b1;
    repeat (6) @(posedge clock);
    chk(ana.detector_power, 1'b0);
    deep_sleep <= 1'b0;
    repeat (6) @(posedge clock);
    chk(ana.detector_power, 1'b1);
    lb <= 1'b1;
    wait_chk(10, 1'b0, 1'b1);
    lb <= 1'b0;
    wait_chk(10, 1'b0, 1'b0);
    unlock(4);
    bus(1'b0, 6'h00, 8'h02);
    rd(6'h00, 32'h04);
    unlock(0);
    bus(1'b0, 6'h00, 8'h02);
    rd(6'h00, 32'h06);
    deep_sleep <= 1'b1;
    repeat (5) @(posedge clock);
    chk(ana.detector_power, 1'b0);
    repeat (30) @(posedge clock);
    chk(ana.detector_power, 1'b1);
    lb <= 1'b1;
    wait_chk(10, 1'b0, 1'b0);
    wait_chk(190, 1'b0, 1'b1);
    deep_sleep <= 1'b0;
    lb <= 1'b0;
    wait_chk(10, 1'b0, 1'b0);
    bus(1'b0, 6'h20, 8'h01);
    rd(6'h20, 32'h01);
    bus(1'b0, 6'h24, 8'h05);
    rd(6'h28, 32'h01);
    wait_chk(1, 1'b1, 1'b1);
    chk(vec, 8'h05);
    dbg <= 1'b1;
    wait_chk(2, 1'b1, 1'b0);
    dbg <= 1'b0;
    lw <= 1'b1;
    repeat (10) @(posedge clock);
    rd(6'h2c, 32'h01);
    bus(1'b0, 6'h28, 8'h00);
    wait_chk(2, 1'b1, 1'b1);
    bus(1'b0, 6'h28, 8'h01);
    wait_chk(2, 1'b1, 1'b0);
    bus(1'b0, 6'h24, 8'h01);
    lw <= 1'b0;
    wait_chk(10, 1'b1, 1'b0);
    lw <= 1'b1;
    wait_chk(10, 1'b1, 1'b1);
    // Second reset with other fuses: wait-mode active, detector off in sleep
    fuse <= 8'he2;
    reset_n <= 1'b0;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    rd(6'h00, 32'h1c);
    rd(6'h04, 32'h02);
    deep_sleep <= 1'b1;
    repeat (4) @(posedge clock);
    deep_sleep <= 1'b0;
    repeat (3) @(posedge clock);
    chk(hold, 1'b1);
    repeat (6) @(posedge clock);
    chk(hold, 1'b0);
    give_verdict;
  end
endmodule // tb
`default_nettype wire
